// >>> rtl/bit_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin inputs.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] d, // Asynchronous inputs.
    output logic [WIDTH-1:0] q // Synchronised outputs.
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// >>> rtl/expander_consts.svh
// Purpose: Constants for the eight-bit I/O expander.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Register pointers, reset values and slave address base.
`ifndef EXPANDER_CONSTS_SVH
`define EXPANDER_CONSTS_SVH

// Register pointers carried in the command byte.
`define EXP_PTR_INPUT 2'h0
`define EXP_PTR_OUTPUT 2'h1
`define EXP_PTR_POLARITY 2'h2
`define EXP_PTR_DIRECTION 2'h3

// Reset values; a set direction bit means input.
`define EXP_RST_OUTPUT 8'hFF
`define EXP_RST_POLARITY 8'h00
`define EXP_RST_DIRECTION 8'hFF

// Upper six bits of the 7-bit slave address; value is arbitrary.
`define EXP_ADDR_BASE 6'h10

// Bits in one serial byte.
`define EXP_BYTE_BITS 4'h8

`endif

// >>> rtl/expander_pkg.sv
// Purpose: Types shared by the I/O expander design files.
// Assumes: Nothing is imported; users write expander_pkg::name.
// Notes: Serial engine states are one-hot.
package expander_pkg;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ACK_A = 9'h004,
        ST_CMD = 9'h008,
        ST_ACK_C = 9'h010,
        ST_WDATA = 9'h020,
        ST_ACK_W = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK = 9'h100
    } bus_state_e;

    typedef logic [7:0] port_t;

endpackage

// >>> rtl/i2c_eight_bit_io_expander.sv
// Purpose: Eight-bit I/O expander behind a two-wire serial slave.
// Assumes: rst_b combines power-on reset and the external reset pin.
// Notes: The bus is oversampled at 200 MHz; any fast-mode rate works.
`timescale 1ns/1ps
`include "expander_consts.svh"
module i2c_eight_bit_io_expander #(
    parameter int WIDTH = 8
) (
    input wire logic clk, // System clock, 200 MHz.
    input wire logic rst_b, // Reset, active low, asynchronous.
    input wire logic scl_i, // Serial clock pin level.
    input wire logic sda_i, // Serial data pin level.
    output logic sda_o, // Serial data drive value, always low.
    output logic sda_oe, // Pulls serial data low when high.
    input wire logic addr_i, // Address select pin.
    input wire logic [WIDTH-1:0] p_i, // Port pin levels.
    output logic [WIDTH-1:0] p_o, // Port pin drive values.
    output logic [WIDTH-1:0] p_oe, // Port pin drive enables.
    output logic int_o, // Change alert drive value, always low.
    output logic int_oe // Pulls the change alert low when high.
);
    localparam int SW = WIDTH + 3;

    expander_pkg::bus_state_e st_q;
    expander_pkg::bus_state_e st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic rw_q;
    logic rw_d;
    logic [1:0] ptr_q;
    logic [1:0] ptr_d;
    logic sda_oe_q;
    logic sda_oe_d;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;
    logic [WIDTH-1:0] pol_q;
    logic [WIDTH-1:0] pol_d;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;
    logic [WIDTH-1:0] oe_q;
    logic int_oe_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic snap_load;
    logic [SW-1:0] sync_w;
    logic scl_s;
    logic sda_s;
    logic addr_s;
    logic [WIDTH-1:0] pins_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [6:0] dev_addr;

    port_if #(.WIDTH(WIDTH)) mon_if ();

    bit_sync #(.WIDTH(SW)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({scl_i, sda_i, addr_i, p_i}),
        .q(sync_w)
    );

    port_monitor #(.WIDTH(WIDTH)) u_mon (
        .clk(clk),
        .rst_b(rst_b),
        .mon(mon_if.mon)
    );

    assign scl_s = sync_w[SW-1];
    assign sda_s = sync_w[SW-2];
    assign addr_s = sync_w[SW-3];
    assign pins_s = sync_w[WIDTH-1:0];
    assign mon_if.pins = pins_s;
    assign mon_if.dir = dir_q;
    assign mon_if.snap_load = snap_load;

    // Edges and bus conditions are taken from the synchronised levels.
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign start_c = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_c = scl_s && scl_prev_q && !sda_prev_q && sda_s;
    assign dev_addr = {`EXP_ADDR_BASE, addr_s};

    // Selects the value a read returns for a register pointer.
    function automatic logic [7:0] read_sel(
        input logic [1:0] ptr,
        input logic [WIDTH-1:0] pins,
        input logic [WIDTH-1:0] outv,
        input logic [WIDTH-1:0] pol,
        input logic [WIDTH-1:0] dir
    );
        logic [7:0] v;
        v = 8'h00;
        case (ptr)
            `EXP_PTR_INPUT: v[WIDTH-1:0] = pins ^ pol;
            `EXP_PTR_OUTPUT: v[WIDTH-1:0] = outv;
            `EXP_PTR_POLARITY: v[WIDTH-1:0] = pol;
            default: v[WIDTH-1:0] = dir;
        endcase
        return v;
    endfunction

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        rw_d = rw_q;
        ptr_d = ptr_q;
        sda_oe_d = sda_oe_q;
        out_d = out_q;
        pol_d = pol_q;
        dir_d = dir_q;
        snap_load = 1'b0;
        if (start_c) begin
            st_d = expander_pkg::ST_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else if (stop_c) begin
            st_d = expander_pkg::ST_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            case (st_q)
                expander_pkg::ST_ADDR,
                expander_pkg::ST_CMD,
                expander_pkg::ST_WDATA: begin
                    if (scl_rise && cnt_q != `EXP_BYTE_BITS) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `EXP_BYTE_BITS) begin
                        cnt_d = 4'h0;
                        sda_oe_d = 1'b1;
                        case (st_q)
                            expander_pkg::ST_ADDR: begin
                                if (sh_q[7:1] == dev_addr) begin
                                    rw_d = sh_q[0];
                                    st_d = expander_pkg::ST_ACK_A;
                                end else begin
                                    sda_oe_d = 1'b0;
                                    st_d = expander_pkg::ST_IDLE;
                                end
                            end
                            expander_pkg::ST_CMD: begin
                                ptr_d = sh_q[1:0];
                                st_d = expander_pkg::ST_ACK_C;
                            end
                            default: begin
                                // The input register ignores writes.
                                case (ptr_q)
                                    `EXP_PTR_OUTPUT: out_d = sh_q[WIDTH-1:0];
                                    `EXP_PTR_POLARITY: pol_d = sh_q[WIDTH-1:0];
                                    `EXP_PTR_DIRECTION: dir_d = sh_q[WIDTH-1:0];
                                    default: dir_d = dir_q;
                                endcase
                                st_d = expander_pkg::ST_ACK_W;
                            end
                        endcase
                    end
                end
                expander_pkg::ST_ACK_A: begin
                    if (scl_fall && rw_q) begin
                        sh_d = read_sel(ptr_q, pins_s, out_q, pol_q, dir_q);
                        sda_oe_d = !sh_d[7];
                        snap_load = (ptr_q == `EXP_PTR_INPUT);
                        st_d = expander_pkg::ST_RDATA;
                    end else if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        st_d = expander_pkg::ST_CMD;
                    end
                end
                expander_pkg::ST_ACK_C,
                expander_pkg::ST_ACK_W: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        st_d = expander_pkg::ST_WDATA;
                    end
                end
                expander_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `EXP_BYTE_BITS) begin
                        cnt_d = 4'h0;
                        sda_oe_d = 1'b0;
                        st_d = expander_pkg::ST_RACK;
                    end else if (scl_fall) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        sda_oe_d = !sh_d[7];
                    end
                end
                expander_pkg::ST_RACK: begin
                    // A released line on the ninth clock ends the read.
                    if (scl_rise && sda_s) begin
                        st_d = expander_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        sh_d = read_sel(ptr_q, pins_s, out_q, pol_q, dir_q);
                        sda_oe_d = !sh_d[7];
                        snap_load = (ptr_q == `EXP_PTR_INPUT);
                        st_d = expander_pkg::ST_RDATA;
                    end
                end
                default: begin
                    st_d = expander_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= expander_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            ptr_q <= `EXP_PTR_INPUT;
            sda_oe_q <= 1'b0;
            out_q <= `EXP_RST_OUTPUT;
            pol_q <= `EXP_RST_POLARITY;
            dir_q <= `EXP_RST_DIRECTION;
            oe_q <= '0;
            int_oe_q <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            rw_q <= rw_d;
            ptr_q <= ptr_d;
            sda_oe_q <= sda_oe_d;
            out_q <= out_d;
            pol_q <= pol_d;
            dir_q <= dir_d;
            oe_q <= ~dir_d;
            int_oe_q <= mon_if.change;
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;
    assign p_o = out_q;
    assign p_oe = oe_q;
    assign int_o = 1'b0;
    assign int_oe = int_oe_q;

    a_dir_write_oe: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_q == expander_pkg::ST_WDATA && scl_fall
            && cnt_q == `EXP_BYTE_BITS && ptr_q == `EXP_PTR_DIRECTION
            && !start_c && !stop_c)
        |=> ##1 (p_oe == ~$past(sh_q, 2)))
        else $error("direction write not applied to drive enables");

    a_oe_only_write: assert property (
        @(posedge clk) disable iff (!rst_b)
        (p_oe != $past(p_oe)) |-> (st_q == expander_pkg::ST_ACK_W))
        else $error("drive enables changed without a write");

    a_out_write_pins: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_q == expander_pkg::ST_WDATA && scl_fall
            && cnt_q == `EXP_BYTE_BITS && ptr_q == `EXP_PTR_OUTPUT
            && !start_c && !stop_c)
        |=> (p_o == $past(sh_q)))
        else $error("output write not seen on port pins");

    a_input_read_pol: assert property (
        @(posedge clk) disable iff (!rst_b)
        (snap_load && !start_c && !stop_c)
        |=> (sh_q == ($past(pins_s) ^ $past(pol_q))))
        else $error("input read value not polarity adjusted");

    a_read_first_bit: assert property (
        @(posedge clk) disable iff (!rst_b)
        ($rose(st_q == expander_pkg::ST_RDATA)) |-> (sda_oe_q == !sh_q[7]))
        else $error("read data bit not driven on bus");

    a_addr_match_ack: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_q == expander_pkg::ST_ADDR && scl_fall && !start_c && !stop_c
            && cnt_q == `EXP_BYTE_BITS && sh_q[7:1] == dev_addr)
        |=> sda_oe_q ##0 (st_q == expander_pkg::ST_ACK_A))
        else $error("matching address not acknowledged");

    a_stop_idles: assert property (
        @(posedge clk) disable iff (!rst_b)
        (stop_c && !start_c) |=> (st_q == expander_pkg::ST_IDLE && !sda_oe_q))
        else $error("stop did not return engine to idle");

    a_alert_follows: assert property (
        @(posedge clk) disable iff (!rst_b)
        mon_if.change |=> int_oe_q)
        else $error("change alert not pulled low");

    a_count_bound: assert property (
        @(posedge clk) disable iff (!rst_b)
        cnt_q <= `EXP_BYTE_BITS)
        else $error("bit counter overran a byte");
endmodule

// >>> rtl/port_if.sv
// Purpose: Carries pin state and change-detect control between modules.
// Assumes: One controller and one monitor.
// Notes: A set dir bit marks the pin as an input.
`timescale 1ns/1ps
interface port_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] pins;
    logic [WIDTH-1:0] dir;
    logic snap_load;
    logic change;

    modport ctrl (output pins, output dir, output snap_load, input change);
    modport mon (input pins, input dir, input snap_load, output change);
endinterface

// >>> rtl/port_monitor.sv
// Purpose: Holds the input snapshot and flags input pins that differ.
// Assumes: Pins arrive already synchronised.
// Notes: The snapshot follows the pins for three cycles after reset.
`timescale 1ns/1ps
module port_monitor #(
    parameter int WIDTH = 8
) (
    input wire logic clk, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    port_if.mon mon // Pin state and snapshot control.
);
    logic [WIDTH-1:0] snap_q;
    logic [WIDTH-1:0] snap_d;
    logic [2:0] primed_q;
    logic [2:0] primed_d;
    logic change_q;
    logic change_d;

    assign mon.change = change_q;

    // The synchroniser still shows its reset zeros for two cycles, so the
    // snapshot keeps reloading until real pin levels arrive.
    always_comb begin
        snap_d = snap_q;
        primed_d = {primed_q[1:0], 1'b1};
        if (!primed_q[2] || mon.snap_load) begin
            snap_d = mon.pins;
        end
        change_d = primed_q[2] && !mon.snap_load
            && (|((mon.pins ^ snap_q) & mon.dir));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            snap_q <= '0;
            primed_q <= 3'h0;
            change_q <= 1'b0;
        end else begin
            snap_q <= snap_d;
            primed_q <= primed_d;
            change_q <= change_d;
        end
    end

    a_change_on_diff: assert property (
        @(posedge clk) disable iff (!rst_b)
        (primed_q[2] && !mon.snap_load && |((mon.pins ^ snap_q) & mon.dir))
        |=> change_q)
        else $error("input difference did not raise change");

    a_change_read_clear: assert property (
        @(posedge clk) disable iff (!rst_b)
        mon.snap_load ##1 $stable(mon.pins) |=> !change_q)
        else $error("change stayed after input register read");
endmodule

// >>> verif/i2c_eight_bit_io_expander_tb.sv
// Purpose: Self-checking bench for the eight-bit I/O expander.
// Assumes: Master model drives the bus; bench drives pins and reset.
// Notes: Bench inputs change on the falling clock edge.
`timescale 1ns/1ps
`include "expander_consts.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("wrong value %s expected %h seen %h", \
    nm, e, g); end end
module i2c_eight_bit_io_expander_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic addr_i = 1'b0;
    expander_pkg::port_t p_i = 8'hA5;
    expander_pkg::port_t p_o, p_oe;
    logic sda_o, sda_oe, int_o, int_oe, scl_low, sda_low, ack, adr;
    wire scl, sda, int_n;
    int error_cnt = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;
    assign scl = ~scl_low;
    assign sda = ~sda_low & (sda_oe ? sda_o : 1'b1);
    assign int_n = int_oe ? int_o : 1'b1;

    i2c_eight_bit_io_expander #(.WIDTH(8)) u_i2c_eight_bit_io_expander (
        .clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_i(addr_i), .p_i(p_i),
        .p_o(p_o), .p_oe(p_oe), .int_o(int_o), .int_oe(int_oe));

    i2c_master_model u_i2c_master_model (
        .clk(clk), .sda_i(sda), .scl_low(scl_low), .sda_low(sda_low));

    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [1:0] ptr, input logic [7:0] d,
                      output logic ok);
        logic k1, k2, k3;
        k2 = 1'b0;
        k3 = 1'b0;
        u_i2c_master_model.start();
        u_i2c_master_model.byte_out({`EXP_ADDR_BASE, adr, 1'b0}, k1);
        if (k1) begin
            u_i2c_master_model.byte_out({6'h00, ptr}, k2);
            u_i2c_master_model.byte_out(d, k3);
        end
        u_i2c_master_model.stop();
        ok = k1 && k2 && k3;
    endtask

    task automatic chk_reg(input logic [1:0] ptr, input logic [7:0] e);
        logic k;
        logic [7:0] d;
        u_i2c_master_model.start();
        u_i2c_master_model.byte_out({`EXP_ADDR_BASE, adr, 1'b0}, k);
        u_i2c_master_model.byte_out({6'h00, ptr}, k);
        u_i2c_master_model.start();
        u_i2c_master_model.byte_out({`EXP_ADDR_BASE, adr, 1'b1}, k);
        u_i2c_master_model.byte_in(1'b1, d);
        u_i2c_master_model.stop();
        `CHK("register", e, d)
    endtask

    // Two-byte read: the master acknowledges the first byte, so the
    // register is reloaded for the second one.
    task automatic chk_pair(input logic [1:0] ptr, input logic [7:0] e);
        logic k;
        logic [7:0] d0;
        logic [7:0] d1;
        u_i2c_master_model.start();
        u_i2c_master_model.byte_out({`EXP_ADDR_BASE, adr, 1'b0}, k);
        u_i2c_master_model.byte_out({6'h00, ptr}, k);
        u_i2c_master_model.start();
        u_i2c_master_model.byte_out({`EXP_ADDR_BASE, adr, 1'b1}, k);
        u_i2c_master_model.byte_in(1'b0, d0);
        u_i2c_master_model.byte_in(1'b1, d1);
        u_i2c_master_model.stop();
        `CHK("first byte", e, d0)
        `CHK("second byte", e, d1)
    endtask

    task automatic end_test(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        adr = 1'b0;
        clks(10);
        rst_b = 1'b1;
        clks(5);
        `CHK("p_oe", 8'h00, p_oe)
        `CHK("p_o", `EXP_RST_OUTPUT, p_o)
        `CHK("int_oe", 1'b0, int_oe)
        `CHK("sda_oe", 1'b0, sda_oe)
        chk_reg(`EXP_PTR_OUTPUT, `EXP_RST_OUTPUT);
        chk_reg(`EXP_PTR_POLARITY, `EXP_RST_POLARITY);
        chk_reg(`EXP_PTR_DIRECTION, `EXP_RST_DIRECTION);
        chk_reg(`EXP_PTR_INPUT, 8'hA5);
        end_test("reset");

        wr(`EXP_PTR_OUTPUT, 8'h5A, ack);
        `CHK("ack", 1'b1, ack)
        wr(`EXP_PTR_DIRECTION, 8'h0F, ack);
        `CHK("p_oe", 8'hF0, p_oe)
        `CHK("p_o", 8'h5A, p_o)
        chk_reg(`EXP_PTR_OUTPUT, 8'h5A);
        chk_reg(`EXP_PTR_DIRECTION, 8'h0F);
        chk_pair(`EXP_PTR_OUTPUT, 8'h5A);
        end_test("direction");

        p_i = 8'h3C;
        wr(`EXP_PTR_POLARITY, 8'hFF, ack);
        chk_reg(`EXP_PTR_INPUT, 8'hC3);
        wr(`EXP_PTR_INPUT, 8'h00, ack);
        chk_reg(`EXP_PTR_INPUT, 8'hC3);
        wr(`EXP_PTR_POLARITY, 8'h0F, ack);
        chk_reg(`EXP_PTR_POLARITY, 8'h0F);
        chk_reg(`EXP_PTR_INPUT, 8'h33);
        wr(`EXP_PTR_POLARITY, 8'h00, ack);
        end_test("polarity");

        chk_reg(`EXP_PTR_INPUT, 8'h3C);
        clks(5);
        `CHK("int_oe", 1'b0, int_oe)
        p_i = 8'hBC;
        clks(10);
        `CHK("int_oe", 1'b0, int_oe)
        p_i = 8'hBD;
        clks(10);
        `CHK("int_oe", 1'b1, int_oe)
        `CHK("int_n", 1'b0, int_n)
        p_i = 8'hBC;
        clks(10);
        `CHK("int_oe", 1'b0, int_oe)
        `CHK("int_n", 1'b1, int_n)
        p_i = 8'hBE;
        clks(10);
        `CHK("int_oe", 1'b1, int_oe)
        chk_reg(`EXP_PTR_INPUT, 8'hBE);
        clks(5);
        `CHK("int_oe", 1'b0, int_oe)
        end_test("alert");

        adr = 1'b1;
        wr(`EXP_PTR_OUTPUT, 8'h00, ack);
        `CHK("ack", 1'b0, ack)
        `CHK("p_o", 8'h5A, p_o)
        clks(1);
        rst_b = 1'b0;
        addr_i = 1'b1;
        clks(3);
        rst_b = 1'b1;
        clks(5);
        `CHK("p_oe", 8'h00, p_oe)
        `CHK("p_o", `EXP_RST_OUTPUT, p_o)
        chk_reg(`EXP_PTR_DIRECTION, `EXP_RST_DIRECTION);
        adr = 1'b0;
        wr(`EXP_PTR_OUTPUT, 8'h00, ack);
        `CHK("ack", 1'b0, ack)
        adr = 1'b1;
        end_test("address");

        u_i2c_master_model.q_cyc = 125;
        wr(`EXP_PTR_OUTPUT, 8'hC3, ack);
        `CHK("ack", 1'b1, ack)
        `CHK("p_o", 8'hC3, p_o)
        chk_reg(`EXP_PTR_OUTPUT, 8'hC3);
        u_i2c_master_model.q_cyc = 10;
        end_test("slow");
        summarize();
    end
endmodule

// >>> verif/i2c_master_model.sv
// Purpose: Behavioural two-wire bus master driving the expander.
// Assumes: Both lines are open drain with pull-ups in the bench.
// Notes: q_cyc sets a quarter bit in clocks; set it from the bench.
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic clk, // System clock used for pacing.
    input wire logic sda_i, // Resolved serial data level.
    output logic scl_low, // Pulls serial clock low when high.
    output logic sda_low // Pulls serial data low when high.
);
    int q_cyc = 10;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic wq();
        repeat (q_cyc) @(negedge clk);
    endtask

    // Data changes only while the clock is low, a quarter bit after it falls.
    task automatic put_bit(input logic b);
        sda_low = ~b;
        wq();
        scl_low = 1'b0;
        wq();
        wq();
        scl_low = 1'b1;
        wq();
    endtask

    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        wq();
        scl_low = 1'b0;
        wq();
        b = sda_i;
        wq();
        scl_low = 1'b1;
        wq();
    endtask

    // Also serves as a repeated start from the clock-low state.
    task automatic start();
        sda_low = 1'b0;
        wq();
        scl_low = 1'b0;
        wq();
        sda_low = 1'b1;
        wq();
        scl_low = 1'b1;
        wq();
    endtask

    task automatic stop();
        sda_low = 1'b1;
        wq();
        scl_low = 1'b0;
        wq();
        sda_low = 1'b0;
        wq();
    endtask

    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(a);
        ack = ~a;
    endtask

    task automatic byte_in(input logic last, output logic [7:0] b);
        logic x;
        for (int i = 0; i < 8; i++) begin
            get_bit(x);
            b = {b[6:0], x};
        end
        put_bit(last);
    endtask
endmodule
